// ==== hw/modbus_cfg.svh ====
// timing counts, frame codes and field values of the rtu frame logic
`ifndef MODBUS_CFG_SVH
`define MODBUS_CFG_SVH
`define CLK_PERIOD_NS        10
`define CHAR_TIME_NS         160
`define CHAR_CYCLES          (`CHAR_TIME_NS / `CLK_PERIOD_NS)
`define GAP_CYCLES           ((`CHAR_CYCLES * 7 + 1) / 2)
`define TAIL_CYCLES          (`CHAR_CYCLES + `GAP_CYCLES)
`define REPLY_TIMEOUT_CYCLES (`CHAR_CYCLES * 40)
`define STATION_MAX          8'hf7
`define BROADCAST            8'h00
`define CMD_READ             8'h03
`define CMD_WRITE            8'h06
`define CMD_ERR_FLAG         8'h80
`define ERR_FUNC             8'h01
`define ERR_ADDR             8'h02
`define ERR_VALUE            8'h03
`define ERR_FAIL             8'h04
`define RES_OK               8'h00
`define RES_LINK             8'hff
`define READ_MAX             16'h000c
`define REQ_LEN              4'h8
`define CRC_SEED             16'hffff
`define CRC_POLY             16'ha001
`endif

// ==== hw/modbus_pkg.sv ====
// types, states and check-value step shared by both ends
package modbus_pkg;
`include "modbus_cfg.svh"
   typedef logic [7:0]  byte_t;
   typedef logic [15:0] word_t;
   typedef enum logic [2:0] {
      S_RX   = 3'h0,
      S_EXEC = 3'h1,
      S_TX   = 3'h2,
      S_GAP  = 3'h3
   } slave_state_e;
   typedef enum logic [2:0] {
      M_IDLE = 3'h0,
      M_TX   = 3'h1,
      M_RX   = 3'h2,
      M_GAP  = 3'h3,
      M_OUT  = 3'h4
   } master_state_e;
   // one data byte applied to the register: xor low bits, eight shifts
   function automatic word_t crc_step(word_t crc, byte_t data);
      word_t c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage

// ==== hw/modbus_link_if.sv ====
// byte level half-duplex link between master and slave
`timescale 1ns/100ps
interface modbus_link_if;
   logic       mByteValid;
   logic [7:0] mByte;
   logic       mDrive;
   logic       sByteValid;
   logic [7:0] sByte;
   logic       sDrive;
   modport master (
      output mByteValid,
      output mByte,
      output mDrive,
      input  sByteValid,
      input  sByte,
      input  sDrive
   );
   modport slave (
      input  mByteValid,
      input  mByte,
      input  mDrive,
      output sByteValid,
      output sByte,
      output sDrive
   );
endinterface

// ==== hw/modbus_crc.sv ====
// running 16-bit check register, seeded by init with the byte of that cycle
`timescale 1ns/100ps
module modbus_crc
   import modbus_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  init,
   input  wire logic  step,
   input  wire byte_t data,
   output word_t      crc
);
   // only the eight data bits ever reach this register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         crc <= `CRC_SEED;
      end else if (step) begin
         crc <= crc_step(init ? `CRC_SEED : crc, data); // R14 R15 R16
      end else if (init) begin
         crc <= `CRC_SEED; // R14
      end
   end
endmodule

// ==== hw/modbus_rtu_slave_frame.sv ====
// slave end: frame receive, station filter, command decode and reply
`timescale 1ns/100ps
// Operation
// R1 - station addresses 0 to 247, each unique
// R2 - broadcast executes but sends no reply
// R3 - own address requests always get reply
// R4 - idle over 3.5 chars bounds frames
// R5 - one talker at a time, master starts
// R6 - only read 0x03 and write 0x06
// R7 - sixteen-bit word parameters only
// R8 - master reads at most twelve words
// R9 - bad frame or failure gives error reply
// R10 - station, command, address, argument, check
// R11 - count field high first, one is one
// R12 - frame ends with 16-bit check value
// R13 - receiver recomputes and compares check value
// R14 - check register seeded 0xffff, xor low
// R15 - eight right shifts, xor 0xa001 on one
// R16 - only data bits enter the check
// R17 - check value sent low byte first
// R18 - data words sent high byte first
// R19 - address high group, low index
// R20 - foreign station frames ignored, no transmit
module modbus_rtu_slave_frame
   import modbus_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst_n,
   input  wire byte_t   station,
   modbus_link_if.slave link,
   output logic         paramValid,
   output logic         paramWrite,
   output word_t        paramAddr,
   output word_t        paramData,
   input  wire logic    paramReady,
   input  wire logic    paramErr,
   input  wire word_t   paramRdData,
   output logic         rxErr,
   output logic         busy
);
   slave_state_e state;
   byte_t        rxBuf [0:7];
   word_t        rdBuf [0:15];
   logic [3:0]   rxCnt;
   logic [7:0]   gapCnt;
   logic [7:0]   tmr;
   logic [3:0]   wordIdx;
   logic [3:0]   wordCnt;
   logic [5:0]   txIdx;
   logic         isErr;
   logic         noReply;
   byte_t        errCode;
   word_t        rxCrc;
   word_t        txCrc;
   byte_t        txByte;

   wire rxStep = state == S_RX && link.mByteValid;
   wire gapHit = gapCnt == 8'(`GAP_CYCLES);
   // a frame closes only on a full gap after its last byte
   wire frameEnd = state == S_RX && gapHit && rxCnt != 4'h0
                   && !link.mByteValid;
   // an own address outside the legal range never matches
   wire ownOk = station != `BROADCAST && station <= `STATION_MAX;
   wire forUs = ownOk && rxBuf[0] == station;
   wire bcast = rxBuf[0] == `BROADCAST;
   wire isRead = rxBuf[1] == `CMD_READ;
   wire isWrite = rxBuf[1] == `CMD_WRITE;
   wire [15:0] rxAddr = {rxBuf[2], rxBuf[3]};
   wire [15:0] rxArg = {rxBuf[4], rxBuf[5]};
   // residue of zero over the whole frame means the check field matched
   wire frameOk = rxCnt == `REQ_LEN && rxCrc == 16'h0000;
   wire cntOk = rxArg != 16'h0000 && rxArg <= `READ_MAX;
   wire [7:0] chkCode =
      !frameOk ? `ERR_FAIL :
      !(isRead || isWrite) ? `ERR_FUNC :
      (isRead && !cntOk) ? `ERR_VALUE : `RES_OK;
   wire lastWord = isWrite || wordIdx == wordCnt - 4'h1;
   wire [5:0] txLen = isErr ? 6'h03 :
                      isWrite ? 6'h06 :
                      6'h03 + {1'b0, wordCnt, 1'b0};
   wire [5:0] dOff = txIdx - 6'h03;
   wire [15:0] dWord = rdBuf[dOff[4:1]];
   wire sendNow = state == S_TX && tmr == 8'h00;
   wire txDone = sendNow && txIdx == txLen + 6'h01;

   // reply byte chosen by position within the frame
   assign txByte =
      txIdx == txLen ? txCrc[7:0] : // R17
      txIdx > txLen ? txCrc[15:8] : // R17
      txIdx == 6'h00 ? rxBuf[0] :
      txIdx == 6'h01 ? (isErr ? rxBuf[1] | `CMD_ERR_FLAG : rxBuf[1]) :
      isErr ? errCode : // R9
      isWrite ? rxBuf[txIdx[2:0]] :
      txIdx == 6'h02 ? {3'h0, wordCnt, 1'b0} :
      txIdx[0] ? dWord[15:8] : dWord[7:0]; // R18

   assign paramValid = state == S_EXEC;
   assign paramWrite = isWrite;
   assign paramData = rxArg; // R18
   assign busy = state != S_RX;
   // line is held through the trailing gap so no one starts early
   assign link.sDrive = state == S_TX || state == S_GAP; // R5

   modbus_crc rxCrcU (
      .clk   (clk),
      .rst_n (rst_n),
      .init  (rxCnt == 4'h0),
      .step  (rxStep), // R13
      .data  (link.mByte),
      .crc   (rxCrc)
   );

   modbus_crc txCrcU (
      .clk   (clk),
      .rst_n (rst_n),
      .init  (txIdx == 6'h00),
      .step  (sendNow && txIdx < txLen), // R12
      .data  (txByte),
      .crc   (txCrc)
   );

   // idle time since the last received byte, saturating at the gap
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gapCnt <= 8'h00;
      end else if (link.mByteValid) begin
         gapCnt <= 8'h00;
      end else if (!gapHit) begin
         gapCnt <= gapCnt + 8'h01; // R4
      end
   end

   // bytes beyond eight only count, so overlong frames fail the length
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxCnt <= 4'h0;
      end else if (frameEnd) begin
         rxCnt <= 4'h0;
      end else if (rxStep) begin
         if (rxCnt < `REQ_LEN) begin
            rxBuf[rxCnt[2:0]] <= link.mByte; // R10
         end
         if (rxCnt != 4'hf) begin
            rxCnt <= rxCnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (state == S_EXEC && paramReady) begin
         rdBuf[wordIdx] <= paramRdData; // R7
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxErr <= 1'b0;
      end else begin
         rxErr <= frameEnd && !frameOk; // R13
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state           <= S_RX;
         isErr           <= 1'b0;
         noReply         <= 1'b0;
         errCode         <= 8'h00;
         wordIdx         <= 4'h0;
         wordCnt         <= 4'h0;
         paramAddr       <= 16'h0000;
         txIdx           <= 6'h00;
         tmr             <= 8'h00;
         link.sByteValid <= 1'b0;
         link.sByte      <= 8'h00;
      end else begin
         link.sByteValid <= sendNow;
         if (sendNow) begin
            link.sByte <= txByte;
         end
         unique case (state)
            S_RX: begin
               // foreign stations fall through and stay silent
               if (frameEnd && (forUs || bcast)) begin // R1 R20
                  noReply   <= bcast; // R2
                  wordIdx   <= 4'h0;
                  wordCnt   <= rxArg[3:0]; // R11
                  paramAddr <= rxAddr; // R19
                  txIdx     <= 6'h00;
                  tmr       <= 8'h00;
                  isErr     <= chkCode != `RES_OK;
                  errCode   <= chkCode;
                  if (chkCode == `RES_OK) begin // R6
                     state <= S_EXEC;
                  end else if (!bcast) begin
                     state <= S_TX; // R9
                  end
               end
            end
            S_EXEC: begin
               if (paramReady) begin
                  paramAddr <= paramAddr + 16'h0001;
                  wordIdx   <= wordIdx + 4'h1;
                  if (paramErr) begin
                     isErr   <= 1'b1; // R9
                     errCode <= `ERR_ADDR;
                  end
                  if (paramErr || lastWord) begin
                     state <= noReply ? S_RX : S_TX; // R2 R3
                  end
               end
            end
            S_TX: begin
               tmr <= tmr == 8'(`CHAR_CYCLES - 1) ? 8'h00 : tmr + 8'h01;
               if (sendNow) begin
                  txIdx <= txIdx + 6'h01;
               end
               if (txDone) begin
                  tmr   <= 8'h00;
                  state <= S_GAP;
               end
            end
            S_GAP: begin
               // last character plus a full gap before listening again
               tmr <= tmr + 8'h01;
               if (tmr == 8'(`TAIL_CYCLES)) begin // R4
                  state <= S_RX;
               end
            end
            default: begin
               state <= S_RX;
            end
         endcase
      end
   end
endmodule

// ==== hw/modbus_rtu_master.sv ====
// master end: builds requests, collects and checks replies
`timescale 1ns/100ps
module modbus_rtu_master
   import modbus_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   modbus_link_if.master link,
   input  wire logic     cmdValid,
   output logic          cmdReady,
   input  wire logic     cmdRead,
   input  wire byte_t    cmdStation,
   input  wire word_t    cmdAddr,
   input  wire word_t    cmdArg,
   output logic          wordValid,
   output word_t         wordData,
   output logic          doneValid,
   output byte_t         doneCode
);
   master_state_e state;
   byte_t         txBuf [0:5];
   byte_t         rxBuf [0:31];
   logic [3:0]    txIdx;
   logic [3:0]    wordIdx;
   logic [5:0]    rxCnt;
   logic [7:0]    gapCnt;
   logic [11:0]   tmr;
   word_t         txCrc;
   word_t         rxCrc;
   byte_t         txByte;

   wire nBad = cmdArg == 16'h0000 || cmdArg > `READ_MAX;
   wire sendNow = state == M_TX && tmr == 12'h000;
   wire rxStep = state == M_RX && link.sByteValid;
   wire gapHit = gapCnt == 8'(`GAP_CYCLES);
   wire frameEnd = state == M_RX && gapHit && rxCnt != 6'h00
                   && !link.sByteValid;
   wire isRd = txBuf[1] == `CMD_READ;
   wire [3:0] nWords = txBuf[5][3:0];
   wire [5:0] rdLen = 6'h05 + {1'b0, nWords, 1'b0};
   wire [4:0] wIdx = {wordIdx, 1'b0} + 5'h03;
   wire [7:0] code =
      rxCrc != 16'h0000 || rxBuf[0] != txBuf[0] ? `RES_LINK :
      rxBuf[1] == (txBuf[1] | `CMD_ERR_FLAG) && rxCnt == 6'h05 ?
         rxBuf[2] :
      rxBuf[1] != txBuf[1] ? `RES_LINK :
      isRd ? (rxBuf[2] == {3'h0, nWords, 1'b0} && rxCnt == rdLen ?
              `RES_OK : `RES_LINK) :
      rxCnt == 6'h08 ? `RES_OK : `RES_LINK;

   assign txByte = txIdx < 4'h6 ? txBuf[txIdx[2:0]] :
                   txIdx == 4'h6 ? txCrc[7:0] : txCrc[15:8]; // R17
   // no new request while the slave still holds the line for its tail
   assign cmdReady = state == M_IDLE && !link.sDrive; // R5
   // the last byte strobe falls after the state has left transmit
   assign link.mDrive = state == M_TX || link.mByteValid; // R5

   modbus_crc txCrcU (
      .clk   (clk),
      .rst_n (rst_n),
      .init  (txIdx == 4'h0),
      .step  (sendNow && txIdx < 4'h6), // R12
      .data  (txByte),
      .crc   (txCrc)
   );

   modbus_crc rxCrcU (
      .clk   (clk),
      .rst_n (rst_n),
      .init  (rxCnt == 6'h00),
      .step  (rxStep), // R13
      .data  (link.sByte),
      .crc   (rxCrc)
   );

   always_ff @(posedge clk) begin
      if (cmdReady && cmdValid) begin
         txBuf <= '{cmdStation, cmdRead ? `CMD_READ : `CMD_WRITE,
                    cmdAddr[15:8], cmdAddr[7:0],
                    cmdArg[15:8], cmdArg[7:0]}; // R6 R10 R11 R18
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gapCnt <= 8'h00;
      end else if (link.sByteValid) begin
         gapCnt <= 8'h00;
      end else if (!gapHit) begin
         gapCnt <= gapCnt + 8'h01; // R4
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rxCnt <= 6'h00;
      end else if (state == M_TX) begin
         rxCnt <= 6'h00;
      end else if (rxStep) begin
         if (!rxCnt[5]) begin
            rxBuf[rxCnt[4:0]] <= link.sByte;
         end
         if (rxCnt != 6'h3f) begin
            rxCnt <= rxCnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state           <= M_IDLE;
         txIdx           <= 4'h0;
         wordIdx         <= 4'h0;
         tmr             <= 12'h000;
         doneValid       <= 1'b0;
         doneCode        <= 8'h00;
         wordValid       <= 1'b0;
         wordData        <= 16'h0000;
         link.mByteValid <= 1'b0;
         link.mByte      <= 8'h00;
      end else begin
         doneValid       <= 1'b0;
         wordValid       <= 1'b0;
         link.mByteValid <= sendNow;
         if (sendNow) begin
            link.mByte <= txByte;
         end
         unique case (state)
            M_IDLE: begin
               tmr   <= 12'h000;
               txIdx <= 4'h0;
               if (cmdValid && cmdReady && cmdRead && nBad) begin
                  doneValid <= 1'b1; // R8
                  doneCode  <= `ERR_VALUE;
               end else if (cmdValid && cmdReady) begin
                  state <= M_TX;
               end
            end
            M_TX: begin
               tmr <= tmr == 12'(`CHAR_CYCLES - 1) ? 12'h000 : tmr + 12'h001;
               if (sendNow) begin
                  txIdx <= txIdx + 4'h1;
               end
               if (sendNow && txIdx == 4'h7) begin
                  tmr   <= 12'h000;
                  state <= txBuf[0] == `BROADCAST ? M_GAP : M_RX; // R2
               end
            end
            M_GAP: begin
               tmr <= tmr + 12'h001;
               if (tmr == 12'(`TAIL_CYCLES)) begin // R4
                  doneValid <= 1'b1;
                  doneCode  <= `RES_OK;
                  state     <= M_IDLE;
               end
            end
            M_RX: begin
               tmr     <= tmr + 12'h001;
               wordIdx <= 4'h0;
               if (frameEnd && code == `RES_OK && isRd) begin
                  state <= M_OUT;
               end else if (frameEnd) begin
                  doneValid <= 1'b1; // R13
                  doneCode  <= code;
                  state     <= M_IDLE;
               end else if (rxCnt == 6'h00
                            && tmr == 12'(`REPLY_TIMEOUT_CYCLES)) begin
                  doneValid <= 1'b1; // R3
                  doneCode  <= `RES_LINK;
                  state     <= M_IDLE;
               end
            end
            M_OUT: begin
               wordValid <= 1'b1;
               wordData  <= {rxBuf[wIdx], rxBuf[wIdx + 5'h01]}; // R18
               wordIdx   <= wordIdx + 4'h1;
               if (wordIdx == nWords - 4'h1) begin
                  doneValid <= 1'b1;
                  doneCode  <= `RES_OK;
                  state     <= M_IDLE;
               end
            end
            default: begin
               state <= M_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== test/modbus_rtu_slave_frame_props.sv ====
// link checker: ownership, pacing and gaps on the rtu byte link
`timescale 1ns/100ps
`include "modbus_cfg.svh"
module modbus_rtu_slave_frame_props (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       mByteValid,
   input wire logic [7:0] mByte,
   input wire logic       mDrive,
   input wire logic       sByteValid,
   input wire logic [7:0] sByte,
   input wire logic       sDrive
);
   localparam int         GAP = `GAP_CYCLES;
   localparam logic [9:0] SAT = 10'h3ff;
   logic [9:0] mIdle;
   logic [9:0] sIdle;
   logic [7:0] mHead;
   // idle counts saturate so a long quiet line never wraps to a short one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mIdle <= SAT;
         sIdle <= SAT;
         mHead <= 8'h00;
      end else begin
         mIdle <= mByteValid ? 10'h000 : (mIdle == SAT ? SAT : mIdle + 1'b1);
         sIdle <= sByteValid ? 10'h000 : (sIdle == SAT ? SAT : sIdle + 1'b1);
         if (mByteValid && mIdle > GAP) begin
            mHead <= mByte;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   half_duplex_a: assert property (!(mDrive && sDrive))
      else $error("master and slave drive the line together");
   master_owns_a: assert property (mByteValid |-> mDrive)
      else $error("master byte sent without owning the line");
   slave_owns_a: assert property (sByteValid |-> sDrive)
      else $error("slave byte sent without owning the line");
   master_pace_a: assert property (
      mByteValid |=> !mByteValid [*8] ##1 !mByteValid [*7])
      else $error("master bytes closer than one character");
   slave_pace_a: assert property (
      sByteValid |=> !sByteValid [*8] ##1 !sByteValid [*7])
      else $error("slave bytes closer than one character");
   reply_gap_a: assert property ($rose(sDrive) |-> mIdle >= GAP)
      else $error("slave took the line before the frame gap");
   request_gap_a: assert property ($rose(mDrive) |-> sIdle >= GAP)
      else $error("master took the line before the frame gap");
   slave_tail_a: assert property ($fell(sDrive) |-> sIdle >= GAP)
      else $error("slave released the line too early");
   reply_head_a: assert property (
      sByteValid && sIdle > GAP |-> sByte == mHead)
      else $error("reply does not start with the request station");
   bcast_quiet_a: assert property ($rose(sDrive) |-> mHead != 8'h00)
      else $error("slave answered a broadcast");
endmodule

// ==== test/modbus_rtu_slave_frame_tb_top.sv ====
// testbench: master and slave ends joined on one link
`timescale 1ns/100ps
`include "modbus_cfg.svh"
module modbus_rtu_slave_frame_tb_top
   import modbus_pkg::*;
();
   localparam byte_t STA = `STATION_MAX;
   logic        clk;
   logic        rst_n;
   logic        cmdValid;
   logic        cmdReady;
   logic        cmdRead;
   byte_t       cmdStation;
   word_t       cmdAddr;
   word_t       cmdArg;
   logic        wordValid;
   word_t       wordData;
   logic        doneValid;
   byte_t       doneCode;
   logic        paramValid;
   logic        paramWrite;
   word_t       paramAddr;
   word_t       paramData;
   logic        paramReady;
   logic        paramErr;
   word_t       paramRdData;
   logic        rxErr;
   logic        busy;
   logic        refuse;
   byte_t       lastCode;
   int          errors;
   int          compares;
   int          doneCnt;
   int          rxCnt;
   byte_t       mq[$];
   byte_t       sq[$];
   word_t       wq[$];
   logic [32:0] pq[$];

   modbus_link_if modbus_link_if_i ();
   modbus_rtu_master modbus_rtu_master_i (
      .clk       (clk),
      .rst_n     (rst_n),
      .link      (modbus_link_if_i.master),
      .cmdValid  (cmdValid),
      .cmdReady  (cmdReady),
      .cmdRead   (cmdRead),
      .cmdStation(cmdStation),
      .cmdAddr   (cmdAddr),
      .cmdArg    (cmdArg),
      .wordValid (wordValid),
      .wordData  (wordData),
      .doneValid (doneValid),
      .doneCode  (doneCode)
   );
   modbus_rtu_slave_frame modbus_rtu_slave_frame_i (
      .clk        (clk),
      .rst_n      (rst_n),
      .station    (STA),
      .link       (modbus_link_if_i.slave),
      .paramValid (paramValid),
      .paramWrite (paramWrite),
      .paramAddr  (paramAddr),
      .paramData  (paramData),
      .paramReady (paramReady),
      .paramErr   (paramErr),
      .paramRdData(paramRdData),
      .rxErr      (rxErr),
      .busy       (busy)
   );
   modbus_rtu_slave_frame_props modbus_rtu_slave_frame_props_i (
      .clk       (clk),
      .rst_n     (rst_n),
      .mByteValid(modbus_link_if_i.mByteValid),
      .mByte     (modbus_link_if_i.mByte),
      .mDrive    (modbus_link_if_i.mDrive),
      .sByteValid(modbus_link_if_i.sByteValid),
      .sByte     (modbus_link_if_i.sByte),
      .sDrive    (modbus_link_if_i.sDrive)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // parameter store: accepts one cycle after a request, then every other cycle, data by address
   always @(negedge clk) begin
      paramReady  <= paramValid && !paramReady && rst_n;
      paramRdData <= paramAddr ^ 16'h5a5a;
      paramErr    <= refuse;
   end
   always @(posedge clk) begin
      if (modbus_link_if_i.mByteValid) mq.push_back(modbus_link_if_i.mByte);
      if (modbus_link_if_i.sByteValid) sq.push_back(modbus_link_if_i.sByte);
      if (wordValid) wq.push_back(wordData);
      if (paramValid && paramReady) pq.push_back({paramWrite, paramAddr,
                                                  paramData});
      if (rxErr) rxCnt++;
      if (doneValid) begin
         doneCnt++;
         lastCode = doneCode;
      end
   end

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // own bitwise form, kept apart from the design's step function
   function automatic word_t crc16(input byte_t b[$]);
      word_t c;
      c = 16'hffff;
      foreach (b[i]) begin
         c[7:0] = c[7:0] ^ b[i];
         repeat (8) c = {1'b0, c[15:1]} ^ (c[0] ? 16'ha001 : 16'h0000);
      end
      return c;
   endfunction
   task automatic chk_frame(input byte_t got[$], input byte_t body[$]);
      word_t c;
      c = crc16(body);
      body.push_back(c[7:0]);
      body.push_back(c[15:8]);
      chk(got.size(), body.size());
      foreach (body[i]) chk(got[i], body[i]);
   endtask
   task automatic xfer(input logic rd, input byte_t st, input word_t a,
                       input word_t g);
      int n0;
      n0 = doneCnt;
      mq.delete();
      sq.delete();
      wq.delete();
      pq.delete();
      for (int i = 0; i < 200 && !cmdReady; i++) @(negedge clk);
      cmdValid   = 1'b1;
      cmdRead    = rd;
      cmdStation = st;
      cmdAddr    = a;
      cmdArg     = g;
      @(negedge clk);
      cmdValid = 1'b0;
      for (int i = 0; i < 3000 && doneCnt == n0; i++) @(negedge clk);
      chk(doneCnt, n0 + 1);
      // slave keeps the line for its tail, so let it go quiet first
      repeat (100) @(negedge clk);
      chk(busy, 1'b0);
   endtask

   task automatic t_write();
      byte_t b[$];
      b = {STA, 8'h06, 8'hf3, 8'h0c, 8'h12, 8'h34};
      xfer(1'b0, STA, 16'hf30c, 16'h1234);
      chk(lastCode, 8'h00);
      chk_frame(mq, b);
      chk_frame(sq, b);
      chk(pq.size(), 1);
      chk(pq[0], {1'b1, 16'hf30c, 16'h1234});
   endtask
   task automatic t_read();
      byte_t b[$];
      byte_t r[$];
      word_t w;
      b = {STA, 8'h03, 8'h18};
      r = {STA, 8'h03, 8'h10, 8'h00, 8'h00, 8'h0c};
      xfer(1'b1, STA, 16'h1000, 16'h000c);
      chk(lastCode, 8'h00);
      chk_frame(mq, r);
      chk(wq.size(), 12);
      for (int i = 0; i < 12; i++) begin
         w = (16'h1000 + i[15:0]) ^ 16'h5a5a;
         chk(wq[i], w);
         chk(pq[i][32:16], {1'b0, 16'h1000 + i[15:0]});
         b.push_back(w[15:8]);
         b.push_back(w[7:0]);
      end
      chk_frame(sq, b);
   endtask
   task automatic t_limit();
      word_t cnt[2];
      cnt = '{16'h0000, 16'h000d};
      foreach (cnt[k]) begin
         xfer(1'b1, STA, 16'h1000, cnt[k]);
         chk(lastCode, 8'h03);
         chk(mq.size() + pq.size(), 0);
      end
   endtask
   task automatic t_bcast();
      xfer(1'b0, 8'h00, 16'h2000, 16'h0001);
      chk(lastCode, 8'h00);
      chk(sq.size(), 0);
      chk(pq.size(), 1);
   endtask
   task automatic t_foreign();
      xfer(1'b0, 8'h05, 16'h2000, 16'h0002);
      chk(lastCode, 8'hff);
      chk(sq.size() + pq.size(), 0);
   endtask
   task automatic t_refuse();
      byte_t b[$];
      b = {STA, 8'h86, 8'h02};
      refuse = 1'b1;
      xfer(1'b0, STA, 16'h2001, 16'h00ff);
      refuse = 1'b0;
      chk(lastCode, 8'h02);
      chk_frame(sq, b);
   endtask

   task automatic stop_test();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // seven transfers of under 1500 cycles each fit well inside this span
   initial begin
      #200us;
      errors++;
      stop_test();
   end
   initial begin
      rst_n       = 1'b0;
      cmdValid    = 1'b0;
      cmdRead     = 1'b0;
      cmdStation  = 8'h00;
      cmdAddr     = 16'h0000;
      cmdArg      = 16'h0000;
      refuse      = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_write();
      t_read();
      t_limit();
      t_bcast();
      t_foreign();
      t_refuse();
      chk(rxCnt, 0);
      stop_test();
   end
endmodule
